// ==== common/irf_map.svh ====
// register offsets, field positions, reset values of the request flags
// assumes a 32-bit word-aligned slave; low byte of haddr decodes
`ifndef IRF_MAP_SVH
`define IRF_MAP_SVH

// ------------------------------------------------------------
// byte offsets
// ------------------------------------------------------------
`define IRF_OFS_MAIN_FLAGS 8'h00
`define IRF_OFS_WAKE_FLAGS 8'h04
`define IRF_OFS_EDGE_MAIN 8'h08
`define IRF_OFS_EDGE_WAKE 8'h0c
`define IRF_OFS_ENABLE_MAIN 8'h10
`define IRF_OFS_FUNC_MAIN 8'h14
`define IRF_OFS_FUNC_WAKE 8'h18
`define IRF_OFS_SYSCTL_TWO 8'h1c
`define IRF_OFS_CLEAR_MAIN 8'h20
`define IRF_OFS_CLEAR_WAKE 8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IRF_BIT_DT 7
`define IRF_BIT_TA 6
`define IRF_BIT_WP_EN 5
`define IRF_BIT_DT_ENABLE 0
`define IRF_MAIN_FLAG_MASK 8'hcf
`define IRF_MAIN_RSVD_ONES 8'h30
`define IRF_WAKE_RSVD_ONES 8'hc0
`define IRF_ENABLE_MASK 8'hef
`define IRF_ENABLE_RSVD_ONES 8'h10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define IRF_RST_MAIN_FLAGS 8'h00
`define IRF_RST_WAKE_FLAGS 6'h00
`define IRF_RST_EDGE_MAIN 4'h0
`define IRF_RST_EDGE_WAKE 6'h00
`define IRF_RST_ENABLE 8'h00
`define IRF_RST_FUNC_MAIN 4'h0
`define IRF_RST_FUNC_WAKE 6'h00
`define IRF_RST_PIN_MAIN 4'hf
`define IRF_RST_PIN_WAKE 6'h3f

`endif

// ==== common/irf_pkg.sv ====
// types shared by the request flag block
// assumes irf_map.svh is used alongside for numbers
package irf_pkg;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ext_request_pin;
    logic [5:0] wakeup_pin;
  } irf_pins_type;

  typedef struct packed {
    logic sleep_direct_transition;
    logic timer_a_overflow;
  } irf_events_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } irf_ahb_out_type;

  // ------------------------------------------------------------
  // whole module state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] main_flags;
    logic [5:0] wake_flags;
    logic [3:0] edge_main;
    logic [5:0] edge_wake;
    logic [7:0] enable_main;
    logic [3:0] func_main;
    logic [5:0] func_wake;
    logic dt_enable;
    logic [3:0] prev_main;
    logic [5:0] prev_wake;
    logic wr_pend;
    logic [7:0] wr_addr;
    irf_ahb_out_type bus;
    logic irq;
  } irf_state_type;

endpackage

// ==== src/irf_top.sv ====
// interrupt request flag registers with an ahb-lite slave port
// assumes pins and event strobes are synchronous to hclk
// assumes single word transfers from one master
//
// Behaviour
// - sleep direct transition sets flag bit seven
// - timer a overflow sets flag bit six
// - reserved flag bits always read one
// - selected edge on request pin sets flag
// - selected edge on wakeup pin sets flag
// - main flags clear by writing zero, or by writing one to the main clear register
// - wakeup flags clear by writing zero, or by writing one to the wakeup clear register
// - edge select zero falling, one rising
// - one shared enable gates all wakeup flags
// - switching pin function may set its flag
`timescale 1ns/1ps
`include "irf_map.svh"

module irf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire irf_pkg::irf_pins_type pins,
  input wire irf_pkg::irf_events_type events,
  output irf_pkg::irf_ahb_out_type bus_out,
  output logic irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // edge detector shared by both pin groups
  function automatic logic [5:0] irf_edges(
    input logic [5:0] cur,
    input logic [5:0] prev,
    input logic [5:0] rise_sel
  );
    irf_edges = (rise_sel & cur & ~prev) | (~rise_sel & ~cur & prev);
  endfunction

  // pin seen by the detector; idle high when not an interrupt input
  function automatic logic [5:0] irf_gate(
    input logic [5:0] pin,
    input logic [5:0] func
  );
    irf_gate = (pin & func) | ~func;
  endfunction

  // read mux, fed from the next state so a write is seen at once
  function automatic logic [31:0] irf_read(
    input logic [7:0] addr,
    input irf_pkg::irf_state_type st
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      `IRF_OFS_MAIN_FLAGS: begin
        v = (st.main_flags & `IRF_MAIN_FLAG_MASK) | `IRF_MAIN_RSVD_ONES;
      end
      `IRF_OFS_WAKE_FLAGS: begin
        v = {2'b00, st.wake_flags} | `IRF_WAKE_RSVD_ONES;
      end
      `IRF_OFS_EDGE_MAIN: begin
        v = {4'h0, st.edge_main};
      end
      `IRF_OFS_EDGE_WAKE: begin
        v = {2'b00, st.edge_wake};
      end
      `IRF_OFS_ENABLE_MAIN: begin
        v = st.enable_main | `IRF_ENABLE_RSVD_ONES;
      end
      `IRF_OFS_FUNC_MAIN: begin
        v = {4'h0, st.func_main};
      end
      `IRF_OFS_FUNC_WAKE: begin
        v = {2'b00, st.func_wake};
      end
      `IRF_OFS_SYSCTL_TWO: begin
        v = {7'h00, st.dt_enable};
      end
      // clear registers are write-only; unmapped reads zero
      default: begin
        v = 8'h00;
      end
    endcase
    irf_read = {24'h000000, v};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  irf_pkg::irf_state_type state_reg;
  irf_pkg::irf_state_type state_next;

  logic accept;
  logic [5:0] gated_main;
  logic [5:0] gated_wake;
  logic [5:0] edge_hit_main;
  logic [5:0] edge_hit_wake;
  logic [7:0] set_main;
  logic [5:0] set_wake;
  logic [7:0] clr_main;
  logic [5:0] clr_wake;
  logic [7:0] wbyte;
  logic wake_pending;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wbyte = hwdata[7:0];
    accept = hsel & hready & htrans[1];

    // a pin switched in or out of interrupt use can make an edge
    // function switch may set flag
    gated_main = irf_gate({2'b11, pins.ext_request_pin},
                          {2'b00, state_reg.func_main});
    gated_wake = irf_gate(pins.wakeup_pin, state_reg.func_wake);

    edge_hit_main = irf_edges(gated_main,
                              {2'b11, state_reg.prev_main},
                              {2'b00, state_reg.edge_main});
    edge_hit_wake = irf_edges(gated_wake, state_reg.prev_wake,
                              state_reg.edge_wake);

    set_main = {2'b00, 2'b00, edge_hit_main[3:0]};
    set_main[`IRF_BIT_DT] = events.sleep_direct_transition &
                            state_reg.dt_enable;
    set_main[`IRF_BIT_TA] = events.timer_a_overflow;
    set_wake = edge_hit_wake;

    clr_main = 8'h00;
    clr_wake = 6'h00;

    // data phase of a write pending from the last address phase
    if (state_reg.wr_pend) begin
      unique case (state_reg.wr_addr)
        `IRF_OFS_MAIN_FLAGS: begin
          clr_main = ~wbyte & `IRF_MAIN_FLAG_MASK;
        end
        `IRF_OFS_WAKE_FLAGS: begin
          clr_wake = ~wbyte[5:0];
        end
        `IRF_OFS_CLEAR_MAIN: begin
          clr_main = wbyte & `IRF_MAIN_FLAG_MASK;
        end
        `IRF_OFS_CLEAR_WAKE: begin
          clr_wake = wbyte[5:0];
        end
        `IRF_OFS_EDGE_MAIN: begin
          state_next.edge_main = wbyte[3:0];
        end
        `IRF_OFS_EDGE_WAKE: begin
          state_next.edge_wake = wbyte[5:0];
        end
        `IRF_OFS_ENABLE_MAIN: begin
          state_next.enable_main = wbyte & `IRF_ENABLE_MASK;
        end
        `IRF_OFS_FUNC_MAIN: begin
          state_next.func_main = wbyte[3:0];
        end
        `IRF_OFS_FUNC_WAKE: begin
          state_next.func_wake = wbyte[5:0];
        end
        `IRF_OFS_SYSCTL_TWO: begin
          state_next.dt_enable = wbyte[`IRF_BIT_DT_ENABLE];
        end
        // unmapped writes are dropped with an okay answer
        default: begin
          clr_main = 8'h00;
        end
      endcase
    end

    // set beats clear so no event is lost in the clearing cycle
    state_next.main_flags = ((state_reg.main_flags & ~clr_main) |
                             set_main) & `IRF_MAIN_FLAG_MASK;
    state_next.wake_flags = (state_reg.wake_flags & ~clr_wake) |
                            set_wake;

    state_next.prev_main = gated_main[3:0];
    state_next.prev_wake = gated_wake;

    // address phase capture; zero wait states, always okay
    state_next.wr_pend = accept & hwrite;
    if (accept) begin
      state_next.wr_addr = haddr[7:0];
    end
    state_next.bus.hreadyout = 1'b1;
    state_next.bus.hresp = 1'b0;
    if (accept & ~hwrite) begin
      state_next.bus.hrdata = irf_read(haddr[7:0], state_next);
    end else begin
      state_next.bus.hrdata = 32'h00000000;
    end

    wake_pending = (|state_next.wake_flags) &
                   state_next.enable_main[`IRF_BIT_WP_EN];
    state_next.irq = wake_pending |
                     (|(state_next.main_flags & state_next.enable_main &
                        `IRF_MAIN_FLAG_MASK));
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.main_flags <= `IRF_RST_MAIN_FLAGS;
      state_reg.wake_flags <= `IRF_RST_WAKE_FLAGS;
      state_reg.edge_main <= `IRF_RST_EDGE_MAIN;
      state_reg.edge_wake <= `IRF_RST_EDGE_WAKE;
      state_reg.enable_main <= `IRF_RST_ENABLE;
      state_reg.func_main <= `IRF_RST_FUNC_MAIN;
      state_reg.func_wake <= `IRF_RST_FUNC_WAKE;
      state_reg.dt_enable <= 1'b0;
      // pins rest high, so no false edge after reset
      state_reg.prev_main <= `IRF_RST_PIN_MAIN;
      state_reg.prev_wake <= `IRF_RST_PIN_WAKE;
      state_reg.wr_pend <= 1'b0;
      state_reg.wr_addr <= 8'h00;
      state_reg.bus.hrdata <= 32'h00000000;
      state_reg.bus.hreadyout <= 1'b1;
      state_reg.bus.hresp <= 1'b0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus_out = state_reg.bus;
  assign irq = state_reg.irq;

endmodule

// ==== bench/irf_props.sv ====
// checker for the request flag block, watching top ports only
// assumes one ahb master and no wait states
`timescale 1ns/1ps
module irf_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire irf_pkg::irf_pins_type pins,
  input wire irf_pkg::irf_events_type events,
  input wire irf_pkg::irf_ahb_out_type bus_out,
  input wire logic irq
);
  // ----
  // helpers and properties
  // ----
  logic rd;
  logic wr_dp;
  assign rd = hsel & hready & htrans[1] & !hwrite;
  // only a write data phase may take irq down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_dp <= 1'b0;
    else wr_dp <= hsel & hready & htrans[1] & hwrite;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rdy; bus_out.hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_okay; !bus_out.hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_idle; !rd |=> bus_out.hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("hrdata not zero");
  property p_rsvm;
    rd && haddr[7:0] == 8'h00 |=> bus_out.hrdata[31:8] == 24'h0 &&
      bus_out.hrdata[5:4] == 2'b11;
  endproperty
  a_rsvm: assert property (p_rsvm) else $error("main reserved bad");
  property p_rsvw;
    rd && haddr[7:0] == 8'h04 |=> bus_out.hrdata[31:6] == 26'h3;
  endproperty
  a_rsvw: assert property (p_rsvw) else $error("wake reserved bad");
  property p_fell; $fell(irq) |-> $past(wr_dp); endproperty
  a_fell: assert property (p_fell) else $error("irq fell alone");
  property p_rose;
    $rose(irq) |-> (|$past(events)) || $past(pins) != $past(pins, 2) ||
      $past(wr_dp) || $past(wr_dp, 2);
  endproperty
  a_rose: assert property (p_rose) else $error("irq rose alone");
  property p_unmap;
    rd && haddr[7:0] >= 8'h20 |=> bus_out.hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  c_rise: cover property ($rose(irq));
  c_fall: cover property ($fell(irq));
  c_rdm: cover property (rd && haddr[7:0] == 8'h00);
endmodule
bind irf_top irf_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .pins(pins),
  .events(events), .bus_out(bus_out), .irq(irq));

// ==== bench/irf_pins_model.sv ====
// far side: request pins, wakeup pins and event strobes
// assumes the bench holds a go input for exactly one cycle
`timescale 1ns/1ps
module irf_pins_model (
  input wire logic hclk,
  input wire logic [3:0] ext_lvl,
  input wire logic [5:0] wk_lvl,
  input wire logic dt_go,
  input wire logic ta_go,
  output irf_pkg::irf_pins_type pins,
  output irf_pkg::irf_events_type events
);
  // follows the bench levels one cycle late, like a pad register
  always @(posedge hclk) begin
    pins <= {ext_lvl, wk_lvl};
    events <= {dt_go, ta_go};
  end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the request flag block
// assumes no wait states are promised; every wait is bounded
`timescale 1ns/1ps
`include "irf_map.svh"
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic dt_go = 0, ta_go = 0, t, d;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [3:0] ext_lvl = 4'hf, ne;
  logic [5:0] wk_lvl = 6'h3f, nw, ew, xw, h;
  logic [7:0] em, en, xm, wd;
  int errors = 0;
  int n_checks = 0;
  irf_pkg::irf_pins_type pins;
  irf_pkg::irf_events_type events;
  irf_pkg::irf_ahb_out_type bus_out;
  logic irq;
  always #2.5 hclk = ~hclk;
  irf_pins_model pm (.hclk(hclk), .ext_lvl(ext_lvl), .wk_lvl(wk_lvl),
    .dt_go(dt_go), .ta_go(ta_go), .pins(pins), .events(events));
  irf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(bus_out.hreadyout), .pins(pins),
    .events(events), .bus_out(bus_out), .irq(irq));
  // ----
  // tasks and expectations
  // ----
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (bus_out.hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      errors++;
      print_verdict;
    end
  endtask
  task xf(input logic w, input logic [7:0] a, input logic [31:0] dd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dd;
    wt;
    q = bus_out.hrdata;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // per bit: sel one wants a rise, sel zero a fall
  function automatic logic [5:0] hit(logic [5:0] p, c, s);
    return (s & ~p & c) | (~s & p & ~c);
  endfunction
  function automatic logic iexp(logic [7:0] m, logic [5:0] w,
    logic [7:0] n);
    return |(m & n & 8'hcf) | (|w & n[5]);
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(76));
    xm = 8'h0;
    xw = 6'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("main rst", `IRF_OFS_MAIN_FLAGS, 32'h30);
    rc("wake rst", `IRF_OFS_WAKE_FLAGS, 32'hc0);
    rc("unmapped", 8'h40, 32'h0);
    xf(1'b1, `IRF_OFS_FUNC_MAIN, 32'hf);
    xf(1'b1, `IRF_OFS_FUNC_WAKE, 32'h3f);
    xf(1'b1, `IRF_OFS_SYSCTL_TWO, 32'h1);
    repeat (60) begin
      em = 8'($urandom);
      ew = 6'($urandom);
      en = 8'($urandom);
      ne = 4'($urandom);
      nw = 6'($urandom);
      {t, d} = 2'($urandom);
      xf(1'b1, `IRF_OFS_EDGE_MAIN, {24'h0, em});
      xf(1'b1, `IRF_OFS_EDGE_WAKE, {26'h0, ew});
      xf(1'b1, `IRF_OFS_ENABLE_MAIN, {24'h0, en});
      h = hit({2'b0, ext_lvl}, {2'b0, ne}, {2'b0, em[3:0]});
      xm = xm | {d, t, 2'b00, h[3:0]};
      xw = xw | hit(wk_lvl, nw, ew);
      ext_lvl <= ne;
      wk_lvl <= nw;
      ta_go <= t;
      dt_go <= d;
      @(posedge hclk);
      ta_go <= 1'b0;
      dt_go <= 1'b0;
      repeat (3) @(posedge hclk);
      rc("main", `IRF_OFS_MAIN_FLAGS, {24'h0, xm | 8'h30});
      rc("wake", `IRF_OFS_WAKE_FLAGS, {24'h0, 2'b11, xw});
      chk("irq set", {31'h0, irq}, {31'h0, iexp(xm, xw, en)});
      wd = 8'($urandom);
      xf(1'b1, `IRF_OFS_MAIN_FLAGS, {24'h0, wd});
      xf(1'b1, `IRF_OFS_WAKE_FLAGS, {24'h0, wd});
      xm = xm & wd;
      xw = xw & wd[5:0];
      rc("main clr", `IRF_OFS_MAIN_FLAGS, {24'h0, xm | 8'h30});
      rc("wake clr", `IRF_OFS_WAKE_FLAGS, {24'h0, 2'b11, xw});
      chk("irq clr", {31'h0, irq}, {31'h0, iexp(xm, xw, en)});
    end
    // config readback and the write-only clear registers
    rc("edge main", `IRF_OFS_EDGE_MAIN, {28'h0, em[3:0]});
    rc("edge wake", `IRF_OFS_EDGE_WAKE, {26'h0, ew});
    rc("enable", `IRF_OFS_ENABLE_MAIN, {24'h0, en & 8'hef | 8'h10});
    xf(1'b1, `IRF_OFS_CLEAR_WAKE, 32'h3f);
    rc("wake clr reg", `IRF_OFS_WAKE_FLAGS, 32'hc0);
    // direct transition dropped while its enable is off
    xf(1'b1, `IRF_OFS_SYSCTL_TWO, 32'h0);
    rc("sysctl", `IRF_OFS_SYSCTL_TWO, 32'h0);
    xf(1'b1, `IRF_OFS_MAIN_FLAGS, 32'h0);
    dt_go <= 1'b1;
    ta_go <= 1'b1;
    @(posedge hclk);
    dt_go <= 1'b0;
    ta_go <= 1'b0;
    repeat (3) @(posedge hclk);
    rc("dt off", `IRF_OFS_MAIN_FLAGS, 32'h70);
    xf(1'b1, `IRF_OFS_CLEAR_MAIN, 32'h40);
    rc("clr reg", `IRF_OFS_MAIN_FLAGS, 32'h30);
    // pins dropped while their function is off, then switched in
    xf(1'b1, `IRF_OFS_FUNC_MAIN, 32'h0);
    xf(1'b1, `IRF_OFS_EDGE_MAIN, 32'h0);
    ext_lvl <= 4'h0;
    repeat (3) @(posedge hclk);
    xf(1'b1, `IRF_OFS_MAIN_FLAGS, 32'h0);
    rc("func off", `IRF_OFS_MAIN_FLAGS, 32'h30);
    xf(1'b1, `IRF_OFS_FUNC_MAIN, 32'hf);
    rc("func on", `IRF_OFS_MAIN_FLAGS, 32'h3f);
    print_verdict;
  end
endmodule
